// ===== pgm_pkg.sv
// Purpose: constants for the eight-pin port with function selection
// Assumes: 32-bit avalon-mm register bus, byte addresses
// Notes: one register per aligned word
`default_nettype none
package pgm_pkg;
   localparam int PORT_W = 8;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_LATCH = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_READBACK = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_DIR = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_PULSE_EN = 4'hc;
   localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
   localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
   localparam logic [PORT_W-1:0] PULSE_EN_RST = 8'h00;
   // value returned for the write-only direction register
   localparam logic [31:0] DIR_READ_VAL = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
   localparam int SYNC_STAGES = 2;
   // pin bit positions of the shared input functions
   localparam int BIT_CLK_D = 7;
   localparam int BIT_CLK_C = 5;
   localparam int BIT_CLK_B = 3;
   localparam int BIT_CLK_A = 2;
   localparam int BIT_EXT_INTERRUPT_IN_1 = 6;
   localparam int BIT_EXT_INTERRUPT_IN_0 = 4;
endpackage : pgm_pkg
`default_nettype wire

// ===== pgm_sync.sv
// Purpose: two-flop synchroniser for one pin level
// Assumes: single clock domain, clock enable freezes state
// Notes: first stage is read only by the second stage
`default_nettype none
module pgm_sync (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic async_i,
   output logic sync_o
);
   import pgm_pkg::*;
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else if (clk_en_i) begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end
   assign sync_o = sync_reg;
endmodule : pgm_sync
`default_nettype wire

// ===== pgm_port.sv
// Purpose: eight-pin general port with timer, pattern and irq sharing
// Assumes: avalon-mm slave, one-cycle waitrequest on each access
// Notes: pins are three signals each; enable low means driving
//
// What this block does
// - an 8-bit read/write output latch holds the pin output values, reset 0.
// - an 8-bit read-only pin readback register ignores writes.
// - readback gives the latch bit for outputs and the pin level for inputs.
// - timer out wins, else dir 0 is input, else enable picks latch or pattern.
// - bits 7..0 carry timer ch2 b,a, ch1 b,a, ch0 d,c,b,a.
// - pattern bits 15..8 go to port bits 7..0, each gated by its own enable.
// - input pins feed timer clocks d,c,b,a and external interrupts 1 and 0.
// - eight write-only direction bits reset to 0, 1 meaning output.
// - reading the direction register never returns the stored bits.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`default_nettype none
module pgm_port (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [pgm_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [pgm_pkg::PORT_W-1:0] pin_i,
   output logic [pgm_pkg::PORT_W-1:0] pin_o,
   output logic [pgm_pkg::PORT_W-1:0] pin_oe_n_o,
   input wire logic [pgm_pkg::PORT_W-1:0] timer_out_en_i,
   input wire logic [pgm_pkg::PORT_W-1:0] timer_out_i,
   output logic [pgm_pkg::PORT_W-1:0] timer_capture_o,
   input wire logic [pgm_pkg::PORT_W-1:0] pattern_out_i,
   output logic ext_timer_clock_a_o,
   output logic ext_timer_clock_b_o,
   output logic ext_timer_clock_c_o,
   output logic ext_timer_clock_d_o,
   output logic ext_interrupt_in_0_o,
   output logic ext_interrupt_in_1_o
);
   import pgm_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the read mux pads the port byte to a 32-bit word
   if (PORT_W != 8) begin : g_bad_width
      $error("port width must be eight bits");
   end
   // the synchroniser module holds exactly two stages
   if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("synchroniser depth must be two");
   end
   if (BIT_CLK_D >= PORT_W || BIT_EXT_INTERRUPT_IN_1 >= PORT_W) begin : g_bad_bits
      $error("shared input bit outside the port");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [PORT_W-1:0] latch_reg;
   logic [PORT_W-1:0] dir_reg;
   logic [PORT_W-1:0] pen_reg;
   logic [31:0] rdata_reg;
   logic ack_reg;
   logic [PORT_W-1:0] pin_sync;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   for (genvar g = 0; g < PORT_W; g++) begin : g_sync
      pgm_sync u_sync (
         .core_clk_i(core_clk_i),
         .reset_n_i(reset_n_i),
         .clk_en_i(clk_en_i),
         .async_i(pin_i[g]),
         .sync_o(pin_sync[g])
      );
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire req = avs_read_i | avs_write_i;
   wire take = req & ~ack_reg & clk_en_i;
   wire wr_lane0 = take & avs_write_i & avs_byteenable_i[0];
   wire hit_latch = (avs_address_i == OFS_LATCH);
   wire hit_rb = (avs_address_i == OFS_READBACK);
   wire hit_dir = (avs_address_i == OFS_DIR);
   wire hit_pen = (avs_address_i == OFS_PULSE_EN);
   wire [PORT_W-1:0] readback = (dir_reg & latch_reg) |
                                (~dir_reg & pin_sync);
   wire [31:0] rd_mux =
      hit_latch ? {24'h000000, latch_reg} :
      hit_rb ? {24'h000000, readback} :
      hit_dir ? DIR_READ_VAL :
      hit_pen ? {24'h000000, pen_reg} : UNMAPPED_VAL;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         latch_reg <= LATCH_RST;
         dir_reg <= DIR_RST;
         pen_reg <= PULSE_EN_RST;
      end else if (wr_lane0) begin
         if (hit_latch) latch_reg <= avs_writedata_i[PORT_W-1:0];
         if (hit_dir) dir_reg <= avs_writedata_i[PORT_W-1:0];
         if (hit_pen) pen_reg <= avs_writedata_i[PORT_W-1:0];
         // readback ignores writes
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en_i) begin
         ack_reg <= take;
         if (take & avs_read_i) rdata_reg <= rd_mux;
      end
   end

   // ack cycle: waitrequest drops, read data is already registered
   assign avs_waitrequest_o = ~ack_reg;
   assign avs_readdata_o = rdata_reg;

   // ----------------------------------------------------------------
   // pin function selection
   // ----------------------------------------------------------------
   wire [PORT_W-1:0] pat_sel = dir_reg & pen_reg & pattern_out_i;
   wire [PORT_W-1:0] gp_val = pat_sel | (dir_reg & ~pen_reg & latch_reg);
   // timer output overrides direction and enable
   assign pin_o = (timer_out_en_i & timer_out_i) |
                  (~timer_out_en_i & gp_val);
   assign pin_oe_n_o = ~(timer_out_en_i | dir_reg);
   wire [PORT_W-1:0] is_in = ~timer_out_en_i & ~dir_reg;
   assign timer_capture_o = pin_sync & is_in;
   assign ext_timer_clock_d_o = pin_sync[BIT_CLK_D] & is_in[BIT_CLK_D];
   assign ext_timer_clock_c_o = pin_sync[BIT_CLK_C] & is_in[BIT_CLK_C];
   assign ext_timer_clock_b_o = pin_sync[BIT_CLK_B] & is_in[BIT_CLK_B];
   assign ext_timer_clock_a_o = pin_sync[BIT_CLK_A] & is_in[BIT_CLK_A];
   assign ext_interrupt_in_1_o = pin_sync[BIT_EXT_INTERRUPT_IN_1] & is_in[BIT_EXT_INTERRUPT_IN_1];
   assign ext_interrupt_in_0_o = pin_sync[BIT_EXT_INTERRUPT_IN_0] & is_in[BIT_EXT_INTERRUPT_IN_0];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   // bus answer: one acknowledge cycle, then busy again
   sequence ack_s;
      !avs_waitrequest_o;
   endsequence
   sequence busy_s;
      avs_waitrequest_o;
   endsequence
   // reset released and clock enabled on two edges in a row
   sequence running_s;
      reset_n_i && clk_en_i ##1 reset_n_i && clk_en_i;
   endsequence

   latch_write_a: assert property (
      wr_lane0 && hit_latch |=> latch_reg == $past(avs_writedata_i[7:0]))
      else $error("latch not written");
   rb_ignore_a: assert property (
      wr_lane0 && hit_rb |=> $stable(latch_reg) && $stable(dir_reg))
      else $error("readback write changed state");
   rb_value_a: assert property (
      take && avs_read_i && hit_rb |=> avs_readdata_o[7:0] ==
      (($past(dir_reg) & $past(latch_reg)) | (~$past(dir_reg) &
      $past(pin_sync))))
      else $error("readback value wrong");
   timer_prio_a: assert property (
      (timer_out_en_i & (pin_oe_n_o | (pin_o ^ timer_out_i))) == 8'h00)
      else $error("timer output priority broken");
   pattern_gate_a: assert property (
      ((~timer_out_en_i & dir_reg & pen_reg) & (pin_o ^ pattern_out_i))
      == 8'h00)
      else $error("pattern output not routed");
   dir_write_a: assert property (
      wr_lane0 && hit_dir |=> dir_reg == $past(avs_writedata_i[7:0]))
      else $error("direction not written");
   dir_hidden_a: assert property (
      take && avs_read_i && hit_dir |=> avs_readdata_o == DIR_READ_VAL)
      else $error("direction readable");
   irq_input_a: assert property (
      ext_interrupt_in_1_o |-> !dir_reg[BIT_EXT_INTERRUPT_IN_1] && pin_sync[BIT_EXT_INTERRUPT_IN_1])
      else $error("irq fed while output");
   bus_answer_a: assert property (
      take |=> ack_s)
      else $error("bus answer missing");
   bus_release_a: assert property (
      ack_reg && clk_en_i |=> busy_s)
      else $error("waitrequest low too long");
   input_release_a: assert property (
      ((~timer_out_en_i & ~dir_reg) & ~pin_oe_n_o) == 8'h00)
      else $error("input pin driven");
   latch_route_a: assert property (
      ((~timer_out_en_i & dir_reg & ~pen_reg) &
      (pin_oe_n_o | (pin_o ^ latch_reg))) == 8'h00)
      else $error("latch output not routed");
   capture_gate_a: assert property (
      ((timer_out_en_i | dir_reg) & timer_capture_o) == 8'h00)
      else $error("capture fed while output");
   pen_write_a: assert property (
      wr_lane0 && hit_pen |=> pen_reg == $past(avs_writedata_i[7:0]))
      else $error("pulse enable not written");
   byte_lane_a: assert property (
      take && avs_write_i && !avs_byteenable_i[0] |=>
      $stable(latch_reg) && $stable(dir_reg) && $stable(pen_reg))
      else $error("write without lane zero changed state");
   ext_interrupt_in_0_input_a: assert property (
      ext_interrupt_in_0_o |-> !dir_reg[BIT_EXT_INTERRUPT_IN_0] && pin_sync[BIT_EXT_INTERRUPT_IN_0])
      else $error("irq fed while output");
   clk_d_route_a: assert property (
      !timer_out_en_i[BIT_CLK_D] && !dir_reg[BIT_CLK_D] |->
      ext_timer_clock_d_o == pin_sync[BIT_CLK_D])
      else $error("timer clock d not routed");
   clk_c_route_a: assert property (
      !timer_out_en_i[BIT_CLK_C] && !dir_reg[BIT_CLK_C] |->
      ext_timer_clock_c_o == pin_sync[BIT_CLK_C])
      else $error("timer clock c not routed");
   clk_b_route_a: assert property (
      !timer_out_en_i[BIT_CLK_B] && !dir_reg[BIT_CLK_B] |->
      ext_timer_clock_b_o == pin_sync[BIT_CLK_B])
      else $error("timer clock b not routed");
   clk_a_route_a: assert property (
      !timer_out_en_i[BIT_CLK_A] && !dir_reg[BIT_CLK_A] |->
      ext_timer_clock_a_o == pin_sync[BIT_CLK_A])
      else $error("timer clock a not routed");
   // a pin level reaches the port logic two enabled edges later
   sync_delay_a: assert property (
      running_s |=> pin_sync == $past(pin_i, 2))
      else $error("pin synchroniser delay wrong");
   // a low clock enable freezes every register
   freeze_state_a: assert property (
      !clk_en_i |=> $stable(latch_reg) && $stable(dir_reg) &&
      $stable(pen_reg) && $stable(pin_sync) && $stable(ack_reg) &&
      $stable(avs_readdata_o))
      else $error("state moved while clock enable low");
endmodule : pgm_port
`default_nettype wire

// ===== pgm_board.sv
// Purpose: board side of the eight port pins
// Assumes: no pull resistors, the board drives every released pin
// Notes: a driven pin shows the port value, a released one the board
`default_nettype none
module pgm_board (
   input wire logic [7:0] port_pin_i,
   input wire logic [7:0] port_oe_n_i,
   input wire logic [7:0] board_drv_i,
   output logic [7:0] pin_lvl_o
);
   assign pin_lvl_o = (port_pin_i & ~port_oe_n_i) |
                      (board_drv_i & port_oe_n_i);
endmodule : pgm_board
`default_nettype wire

// ===== pgm_port_tb.sv
// Purpose: self-checking bench of the eight-pin port
// Assumes: clock enable high except in the freeze scenario
// Notes: pin inputs come through the board model
`default_nettype none
module pgm_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pgm_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0] wd = '0, rdat, rv;
   logic [7:0] drv = 8'h3c, lvl, po, oe_n, cap, ten = '0, tout = '0;
   logic [7:0] pat = '0, old;
   logic ce = 1'b1;
   logic [3:0] be = 4'hf;
   logic ca, cb, cc, cd, i0, i1;
   int failures = 0, n_checks = 0;
   always #12.5 clk = ~clk;
   pgm_board board (.port_pin_i(po), .port_oe_n_i(oe_n),
      .board_drv_i(drv), .pin_lvl_o(lvl));
   pgm_port dut (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(ce),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pin_i(lvl),
      .pin_o(po), .pin_oe_n_o(oe_n), .timer_out_en_i(ten),
      .timer_out_i(tout), .timer_capture_o(cap), .pattern_out_i(pat),
      .ext_timer_clock_a_o(ca), .ext_timer_clock_b_o(cb),
      .ext_timer_clock_c_o(cc), .ext_timer_clock_d_o(cd),
      .ext_interrupt_in_0_o(i0), .ext_interrupt_in_1_o(i1));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wd <= d;
      @(posedge clk iff wreq === 1'b0);
      rv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("oe_n", 32'hff, oe_n);
      bus(1'b0, OFS_LATCH, '0);
      chk("latch", 32'h0, rv);
   endtask : t_reset
   task automatic t_regs;
      bus(1'b1, OFS_LATCH, 32'ha5);
      be <= 4'he;
      bus(1'b1, OFS_LATCH, 32'hff);
      be <= 4'hf;
      bus(1'b1, OFS_READBACK, 32'h5a);
      bus(1'b0, OFS_LATCH, '0);
      chk("latch", 32'ha5, rv);
      bus(1'b0, OFS_READBACK, '0);
      chk("readback", 32'h3c, rv);
      bus(1'b1, OFS_DIR, 32'hf0);
      bus(1'b0, OFS_READBACK, '0);
      chk("readback", 32'hac, rv);
      bus(1'b0, OFS_DIR, '0);
      chk("dir read", DIR_READ_VAL, rv);
      chk("oe_n", 32'h0f, oe_n);
      chk("pin out", 32'ha0, po & 8'hf0);
   endtask : t_regs
   task automatic t_shared;
      bus(1'b1, OFS_PULSE_EN, 32'hc0);
      bus(1'b0, OFS_PULSE_EN, '0);
      chk("pulse enable", 32'hc0, rv);
      pat <= 8'h7f;
      @(negedge clk);
      chk("pattern", 32'h60, po & 8'hf0);
      @(posedge clk);
      ten <= 8'h81;
      tout <= 8'h81;
      @(negedge clk);
      chk("timer oe_n", 32'h0e, oe_n);
      chk("timer out", 32'he1, po & 8'hf1);
      chk("capture", 32'h0c, cap);
      @(posedge clk);
      ten <= '0;
      bus(1'b1, OFS_DIR, '0);
   endtask : t_shared
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      drv <= 8'h96;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("frozen capture", 32'h50, cap);
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("capture", 32'h96, cap);
   endtask : t_freeze
   task automatic t_rerun;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
   endtask : t_rerun
   task automatic t_inputs(input logic [7:0] nv);
      old = drv;
      @(posedge clk);
      drv <= nv;
      @(posedge clk);
      @(negedge clk);
      chk("capture early", old, cap);
      @(negedge clk);
      chk("capture", nv, cap);
      chk("ext clocks", {nv[7], nv[5], nv[3], nv[2]}, {cd, cc, cb, ca});
      chk("ext irq", {nv[6], nv[4]}, {i1, i0});
   endtask : t_inputs
   initial begin
      #100000;
      failures++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_shared();
      t_inputs(8'hac);
      t_inputs(8'h50);
      t_freeze();
      t_rerun();
      close_out();
   end
endmodule : pgm_port_tb
`default_nettype wire
